//--- rtl/pad_state_defines.svh
`ifndef PAD_STATE_DEFINES_SVH
`define PAD_STATE_DEFINES_SVH

`define PAD_NUM_PINS    8
`define PAD_TYPE_W      4
`define PAD_FUNC_W      4
`define PAD_MODE_W      3
`define PAD_STATE_W     3
`define PAD_ACT_W       4
`define PAD_INIT_W      4
`define PAD_INIT_CYCLES 4'h4
`define PAD_RST_LEVEL   1'h0
`define PAD_SHUT_LEVEL  1'h0
`define PAD_DEBUG_PULL  1'h1

`define ST_CODE_POR     3'h0
`define ST_CODE_EXTRST  3'h1
`define ST_CODE_RUN     3'h3
`define ST_CODE_SBHOLD  3'h2
`define ST_CODE_SBSHUT  3'h6
`define ST_CODE_DSHOLD  3'h7
`define ST_CODE_DSSHUT  3'h5
`define ST_CODE_DSRET   3'h4

`endif

//--- rtl/pad_state_pkg.sv
package pad_state_pkg;
  `include "pad_state_defines.svh"

  typedef enum logic [`PAD_STATE_W-1:0] {
    ST_POR     = `ST_CODE_POR,
    ST_EXT_RST = `ST_CODE_EXTRST,
    ST_RUN     = `ST_CODE_RUN,
    ST_SB_HOLD = `ST_CODE_SBHOLD,
    ST_SB_SHUT = `ST_CODE_SBSHUT,
    ST_DS_HOLD = `ST_CODE_DSHOLD,
    ST_DS_SHUT = `ST_CODE_DSSHUT,
    ST_DS_RET  = `ST_CODE_DSRET
  } cpu_state_t;

  typedef enum logic [`PAD_TYPE_W-1:0] {
    TYPE_A, TYPE_B, TYPE_C, TYPE_D, TYPE_E, TYPE_F,
    TYPE_G, TYPE_H, TYPE_I, TYPE_J, TYPE_K
  } pin_type_t;

  typedef enum logic [`PAD_FUNC_W-1:0] {
    FN_OSC, FN_EXTCLK, FN_GPIO, FN_ANALOG, FN_DEBUG, FN_NMI,
    FN_WAKEUP, FN_EXTINT, FN_I2CS, FN_CEC, FN_OTHER
  } func_sel_t;

  typedef enum logic [`PAD_MODE_W-1:0] {
    PM_RUN, PM_SLEEP, PM_TIMER, PM_RTC, PM_STOP, PM_DS_STOP, PM_DS_RTC
  } pwr_mode_t;

  typedef enum logic [`PAD_ACT_W-1:0] {
    ACT_SHUT, ACT_OPEN, ACT_PULL, ACT_CKG, ACT_OSCR, ACT_OSCS,
    ACT_REG, ACT_NOPU, ACT_HOLD, ACT_HSHUT, ACT_COPY, ACT_ANA
  } pad_act_t;
endpackage

//--- rtl/pad_snap_if.sv
`timescale 1ns/100ps
`include "pad_state_defines.svh"
interface pad_snap_if #(parameter int N_PINS = `PAD_NUM_PINS);
  logic [N_PINS-1:0] live_oe, live_out, live_pu;
  logic [N_PINS-1:0] gpio_oe, gpio_out, gpio_pu;
  logic [N_PINS-1:0] held_oe, held_out, held_pu;
  logic [N_PINS-1:0] copy_oe, copy_out, copy_pu;
  logic              capture;
  modport ctl (output live_oe, live_out, live_pu, gpio_oe, gpio_out, gpio_pu,
               capture, input held_oe, held_out, held_pu, copy_oe, copy_out,
               copy_pu);
  modport store (input live_oe, live_out, live_pu, gpio_oe, gpio_out, gpio_pu,
                 capture, output held_oe, held_out, held_pu, copy_oe, copy_out,
                 copy_pu);
endinterface

//--- rtl/pad_hold_snapshot.sv
`timescale 1ns/100ps
`include "pad_state_defines.svh"
module pad_hold_snapshot #(
  parameter int N_PINS = `PAD_NUM_PINS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  pad_snap_if.store bus
);
  logic [6*N_PINS-1:0] snap_r;
  logic [6*N_PINS-1:0] snap_nxt;

  // The snapshot tracks the live pad values and freezes on leaving the reset and run states.
  always_comb begin
    snap_nxt = snap_r;
    if (bus.capture) begin
      snap_nxt = {bus.live_oe, bus.live_out, bus.live_pu,
                  bus.gpio_oe, bus.gpio_out, bus.gpio_pu};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      snap_r <= {6*N_PINS{`PAD_RST_LEVEL}};
    end else begin
      snap_r <= snap_nxt;
    end
  end

  assign {bus.held_oe, bus.held_out, bus.held_pu,
          bus.copy_oe, bus.copy_out, bus.copy_pu} = snap_r;
endmodule // pad_hold_snapshot

//--- rtl/pad_state_controller.sv
// Contract
// - Shut-off: no drive, no pull, input zero.
// - Input-open: no drive, no pull, input passes.
// - Configured-pull: no drive, pull from config.
// - Clock input gated while oscillator stopped.
// - Oscillator pin runs or stops per state.
// - Register-controlled: drive and pull from registers.
// - Controlled-no-pull: registers drive, pull forced off.
// - Hold-open: keep pre-entry values, input open.
// - Hold-shut: keep pre-entry values, input gated.
// - GPIO-copy: hold pre-entry GPIO values, input gated.
// - Power-on or low-supply reset is state one.
// - External reset or post-power init is state two.
// - Standby holds or shuts by pin-level bit.
// - Deep standby holds gated or shuts by bit.
// - Deep standby return holds while hold bit set.
// - Oscillator function: no drive, no pull, input zero.
// - Digital function on oscillator pin stops oscillator.
// - Analog function: no drive, no pull, input zero.
// - Digital function on analog pin disables analog.
// - Debug pin pulls up in external reset.
// - Pin type without resistor never pulls up.
`timescale 1ns/100ps
`include "pad_state_defines.svh"
module pad_state_controller
  import pad_state_pkg::*;
#(
  parameter int N_PINS = `PAD_NUM_PINS
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              por_in,
  input  wire logic              ext_reset_n_in,
  input  wire pwr_mode_t         pwr_mode_in,
  input  wire logic              standby_pin_level_bit_in,
  input  wire logic              io_hold_control_in,
  input  wire pin_type_t         pin_type_in [N_PINS],
  input  wire func_sel_t         func_sel_in [N_PINS],
  input  wire logic [N_PINS-1:0] gpio_out_in,
  input  wire logic [N_PINS-1:0] gpio_oe_in,
  input  wire logic [N_PINS-1:0] gpio_pu_in,
  input  wire logic [N_PINS-1:0] periph_out_in,
  input  wire logic [N_PINS-1:0] periph_oe_in,
  input  wire logic [N_PINS-1:0] periph_pu_in,
  input  wire logic [N_PINS-1:0] pullup_config_register_in,
  input  wire logic [N_PINS-1:0] osc_running_in,
  input  wire logic [N_PINS-1:0] pad_pin_in,
  output logic      [N_PINS-1:0] pad_out_out,
  output logic      [N_PINS-1:0] pad_oe_out,
  output logic      [N_PINS-1:0] pad_pu_out,
  output logic      [N_PINS-1:0] core_din_out,
  output logic      [N_PINS-1:0] osc_en_out,
  output logic      [N_PINS-1:0] analog_en_out,
  output cpu_state_t             cpu_state_out
);
  function automatic logic [31:0] row8(input pad_act_t a1, a2, a3, a4, a5, a6, a7, a8);
    return {a8, a7, a6, a5, a4, a3, a2, a1};
  endfunction

  localparam logic [31:0] R_OFF = {8{ACT_SHUT}};
  localparam logic [31:0] R_ANA = {8{ACT_ANA}};
  localparam logic [31:0] R_STD = row8(ACT_SHUT, ACT_SHUT, ACT_REG, ACT_HOLD,
                                       ACT_SHUT, ACT_HSHUT, ACT_SHUT, ACT_HSHUT);
  localparam logic [31:0] R_STB = row8(ACT_SHUT, ACT_SHUT, ACT_REG, ACT_HOLD,
                                       ACT_SHUT, ACT_COPY, ACT_SHUT, ACT_COPY);
  localparam logic [31:0] R_MOSC = row8(ACT_OSCS, ACT_OSCS, ACT_OSCR, ACT_OSCR,
                                        ACT_OSCR, ACT_OSCS, ACT_OSCS, ACT_OSCS);
  localparam logic [31:0] R_SOSC = row8(ACT_OSCS, ACT_OSCR, ACT_OSCR, ACT_OSCR,
                                        ACT_OSCR, ACT_OSCR, ACT_OSCR, ACT_OSCR);
  localparam logic [31:0] R_ECLK = row8(ACT_SHUT, ACT_SHUT, ACT_CKG, ACT_CKG,
                                        ACT_CKG, ACT_SHUT, ACT_SHUT, ACT_SHUT);
  localparam logic [31:0] R_GPG = row8(ACT_SHUT, ACT_OPEN, ACT_NOPU, ACT_HOLD,
                                       ACT_SHUT, ACT_HSHUT, ACT_SHUT, ACT_HSHUT);
  localparam logic [31:0] R_GPI = row8(ACT_SHUT, ACT_OPEN, ACT_REG, ACT_HOLD,
                                       ACT_SHUT, ACT_SHUT, ACT_SHUT, ACT_SHUT);
  localparam logic [31:0] R_GPK = row8(ACT_SHUT, ACT_OPEN, ACT_REG, ACT_HOLD,
                                       ACT_SHUT, ACT_HSHUT, ACT_SHUT, ACT_HSHUT);
  localparam logic [31:0] R_DBG = row8(ACT_SHUT, ACT_PULL, ACT_REG, ACT_PULL,
                                       ACT_PULL, ACT_PULL, ACT_PULL, ACT_PULL);
  localparam logic [31:0] R_NMI = row8(ACT_SHUT, ACT_SHUT, ACT_PULL, ACT_PULL,
                                       ACT_PULL, ACT_SHUT, ACT_SHUT, ACT_SHUT);
  localparam logic [31:0] R_WAKE = row8(ACT_SHUT, ACT_SHUT, ACT_PULL, ACT_PULL,
                                        ACT_PULL, ACT_PULL, ACT_PULL, ACT_PULL);
  localparam logic [31:0] R_EXJ = row8(ACT_SHUT, ACT_SHUT, ACT_PULL, ACT_PULL,
                                       ACT_PULL, ACT_COPY, ACT_SHUT, ACT_COPY);
  localparam logic [31:0] R_EXK = row8(ACT_SHUT, ACT_SHUT, ACT_REG, ACT_HOLD,
                                       ACT_PULL, ACT_COPY, ACT_SHUT, ACT_COPY);
  localparam logic [31:0] R_CEC = row8(ACT_SHUT, ACT_SHUT, ACT_NOPU, ACT_NOPU,
                                       ACT_NOPU, ACT_NOPU, ACT_NOPU, ACT_NOPU);

  function automatic logic [2:0] state_idx(input cpu_state_t s);
    unique case (s)
      ST_POR:     return 3'h0;
      ST_EXT_RST: return 3'h1;
      ST_RUN:     return 3'h2;
      ST_SB_HOLD: return 3'h3;
      ST_SB_SHUT: return 3'h4;
      ST_DS_HOLD: return 3'h5;
      ST_DS_SHUT: return 3'h6;
      ST_DS_RET:  return 3'h7;
    endcase
  endfunction

  // Undefined table cells fall back to shut-off, the safest pad state.
  function automatic pad_act_t act_lookup(input pin_type_t t, input func_sel_t f,
                                          input cpu_state_t s);
    logic [31:0] row;
    logic        jk;
    jk = (t == TYPE_J) || (t == TYPE_K);
    case (f)
      FN_OSC:    row = (t == TYPE_A || t == TYPE_B) ? R_MOSC :
                       (t == TYPE_C || t == TYPE_D) ? R_SOSC : R_OFF;
      FN_EXTCLK: row = (t == TYPE_A || t == TYPE_C) ? R_ECLK : R_OFF;
      FN_GPIO:   row = (t == TYPE_B) ? R_STB : (t == TYPE_G) ? R_GPG :
                       (t == TYPE_I) ? R_GPI : (t == TYPE_K) ? R_GPK : R_STD;
      FN_ANALOG: row = (t == TYPE_I) ? R_ANA : R_OFF;
      FN_DEBUG:  row = (t == TYPE_H) ? R_DBG : R_OFF;
      FN_NMI:    row = (t == TYPE_H) ? R_NMI : R_OFF;
      FN_WAKEUP: row = (jk || t == TYPE_I) ? R_WAKE : R_OFF;
      FN_EXTINT: row = (t == TYPE_J) ? R_EXJ : (t == TYPE_K) ? R_EXK : R_OFF;
      FN_I2CS:   row = (t == TYPE_K) ? R_EXK : R_OFF;
      FN_CEC:    row = (t == TYPE_J) ? R_CEC : R_OFF;
      FN_OTHER:  row = jk ? R_STB : R_OFF;
      default:   row = R_OFF;
    endcase
    return pad_act_t'(row[{state_idx(s), 2'h0} +: `PAD_ACT_W]);
  endfunction

  logic                    por_meta_r, por_sync_r, ext_meta_n_r, ext_sync_n_r;
  logic [N_PINS-1:0]       pad_meta_r, pad_sync_r;
  cpu_state_t              cpu_state_r, cpu_state_nxt;
  logic                    ds_wake_r, ds_wake_nxt;
  logic [`PAD_INIT_W-1:0]  init_cnt_r, init_cnt_nxt;
  logic                    no_rst_c;
  logic [N_PINS-1:0]       gpio_own;
  wire  [N_PINS-1:0]       oe_nxt, out_nxt, pu_nxt, din_nxt, osc_nxt, ana_nxt;
  pad_act_t                act_w [N_PINS];

  pad_snap_if #(.N_PINS(N_PINS)) snap_bus ();

  // Reset sources and the pad levels come from outside the clock domain.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {por_meta_r, por_sync_r} <= 2'h3;
      {ext_meta_n_r, ext_sync_n_r} <= 2'h0;
      pad_meta_r <= '0;
      pad_sync_r <= '0;
    end else begin
      {por_meta_r, por_sync_r} <= {por_in, por_meta_r};
      {ext_meta_n_r, ext_sync_n_r} <= {ext_reset_n_in, ext_meta_n_r};
      pad_meta_r <= pad_pin_in;
      pad_sync_r <= pad_meta_r;
    end
  end

  assign no_rst_c = !por_sync_r && ext_sync_n_r && (init_cnt_r == '0);

  always_comb begin
    cpu_state_nxt = ST_RUN;
    ds_wake_nxt   = ds_wake_r;
    init_cnt_nxt  = (init_cnt_r != '0) ? init_cnt_r - 1'h1 : init_cnt_r;
    if (por_sync_r) begin
      cpu_state_nxt = ST_POR;
      ds_wake_nxt   = 1'h0;
      init_cnt_nxt  = `PAD_INIT_CYCLES;
    end else if (!ext_sync_n_r || init_cnt_r != '0) begin
      cpu_state_nxt = ST_EXT_RST;
      ds_wake_nxt   = 1'h0;
    end else begin
      case (pwr_mode_in)
        PM_RUN, PM_SLEEP: begin
          if (ds_wake_r && io_hold_control_in) begin
            cpu_state_nxt = ST_DS_RET;
          end else begin
            ds_wake_nxt = 1'h0;
          end
        end
        PM_TIMER, PM_RTC, PM_STOP: begin
          cpu_state_nxt = standby_pin_level_bit_in ? ST_SB_SHUT : ST_SB_HOLD;
        end
        PM_DS_STOP, PM_DS_RTC: begin
          cpu_state_nxt = standby_pin_level_bit_in ? ST_DS_SHUT : ST_DS_HOLD;
          ds_wake_nxt   = 1'h1;
        end
        default: cpu_state_nxt = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cpu_state_r <= ST_POR;
      ds_wake_r   <= 1'h0;
      init_cnt_r  <= `PAD_INIT_CYCLES;
    end else begin
      cpu_state_r <= cpu_state_nxt;
      ds_wake_r   <= ds_wake_nxt;
      init_cnt_r  <= init_cnt_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      gpio_own[i] = (func_sel_in[i] == FN_GPIO);
    end
  end

  // Hold states need the values in force before entry, so capture stops
  // as soon as the state register leaves the reset and run states.
  assign snap_bus.live_oe  = (gpio_own & gpio_oe_in) | (~gpio_own & periph_oe_in);
  assign snap_bus.live_out = (gpio_own & gpio_out_in) | (~gpio_own & periph_out_in);
  assign snap_bus.live_pu  = (gpio_own & gpio_pu_in) | (~gpio_own & periph_pu_in);
  assign snap_bus.gpio_oe  = gpio_oe_in;
  assign snap_bus.gpio_out = gpio_out_in;
  assign snap_bus.gpio_pu  = gpio_pu_in;
  assign snap_bus.capture  = (cpu_state_r == ST_POR) || (cpu_state_r == ST_EXT_RST)
                             || (cpu_state_r == ST_RUN);

  pad_hold_snapshot #(.N_PINS(N_PINS)) u_snap (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .bus      (snap_bus.store)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic oe_c, out_c, pu_c, din_c, osc_c, ana_c, dbg_c;

    always_comb begin
      act_w[i] = act_lookup(pin_type_in[i], func_sel_in[i], cpu_state_r);
      dbg_c = (pin_type_in[i] == TYPE_H) && (func_sel_in[i] == FN_DEBUG)
              && (cpu_state_r == ST_EXT_RST);
      oe_c  = 1'h0;
      out_c = 1'h0;
      pu_c  = 1'h0;
      din_c = `PAD_SHUT_LEVEL;
      osc_c = 1'h0;
      ana_c = 1'h0;
      unique case (act_w[i])
        ACT_SHUT:  din_c = `PAD_SHUT_LEVEL;
        ACT_OPEN:  din_c = pad_sync_r[i];
        ACT_PULL: begin
          din_c = pad_sync_r[i];
          pu_c  = dbg_c ? `PAD_DEBUG_PULL : pullup_config_register_in[i];
        end
        ACT_CKG:   din_c = osc_running_in[i] & pad_sync_r[i];
        ACT_OSCR:  osc_c = 1'h1;
        ACT_OSCS:  osc_c = 1'h0;
        ACT_REG: begin
          oe_c  = snap_bus.live_oe[i];
          out_c = snap_bus.live_out[i];
          pu_c  = snap_bus.live_pu[i];
          din_c = pad_sync_r[i];
        end
        ACT_NOPU: begin
          oe_c  = snap_bus.live_oe[i];
          out_c = snap_bus.live_out[i];
          din_c = pad_sync_r[i];
        end
        ACT_HOLD, ACT_HSHUT: begin
          oe_c  = snap_bus.held_oe[i];
          out_c = snap_bus.held_out[i];
          pu_c  = snap_bus.held_pu[i];
          din_c = (act_w[i] == ACT_HOLD) ? pad_sync_r[i] : `PAD_SHUT_LEVEL;
        end
        ACT_COPY: begin
          oe_c  = snap_bus.copy_oe[i];
          out_c = snap_bus.copy_out[i];
          pu_c  = snap_bus.copy_pu[i];
        end
        ACT_ANA:   ana_c = 1'h1;
        default:   din_c = `PAD_SHUT_LEVEL;
      endcase
      if (pin_type_in[i] == TYPE_G) begin
        pu_c = 1'h0;
      end
    end

    assign oe_nxt[i]  = oe_c;
    assign out_nxt[i] = out_c;
    assign pu_nxt[i]  = pu_c;
    assign din_nxt[i] = din_c;
    assign osc_nxt[i] = osc_c;
    assign ana_nxt[i] = ana_c;

    sequence run_then_hold;
      cpu_state_r == ST_RUN ##1 act_w[i] == ACT_HOLD;
    endsequence

    chk_shut_pad: assert property (act_w[i] == ACT_SHUT |=> !pad_oe_out[i] &&
                    !pad_pu_out[i] && !core_din_out[i]) else $error("shut pad not quiet");
    chk_open_input: assert property (act_w[i] == ACT_OPEN |=> !pad_oe_out[i] &&
                      core_din_out[i] == $past(pad_sync_r[i])) else $error("open input");
    chk_clock_gate: assert property (act_w[i] == ACT_CKG && !osc_running_in[i]
                      |=> !core_din_out[i] && !pad_pu_out[i]) else $error("clock gate");
    chk_no_pull: assert property (act_w[i] == ACT_NOPU |=> !pad_pu_out[i] &&
                   pad_oe_out[i] == $past(snap_bus.live_oe[i])) else $error("no pull");
    chk_hold_value: assert property (run_then_hold |=>
                      pad_out_out[i] == $past(snap_bus.live_out[i], 2)) else $error("hold");
    chk_copy_gpio: assert property (act_w[i] == ACT_COPY |=> !core_din_out[i] &&
                     pad_oe_out[i] == $past(snap_bus.copy_oe[i])) else $error("copy");
    chk_osc_digital: assert property (func_sel_in[i] != FN_OSC |=> !osc_en_out[i])
                       else $error("oscillator left on");
    // The output registers still load their reset value on the last reset edge.
    chk_analog_pad: assert property (rst_n_in && act_w[i] == ACT_ANA |=>
                      analog_en_out[i] && !pad_oe_out[i] && !core_din_out[i])
                      else $error("analog pad");
    chk_no_resistor: assert property (pin_type_in[i] == TYPE_G |=> !pad_pu_out[i])
                       else $error("pull on resistorless pin");
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pad_oe_out    <= '0;
      pad_out_out   <= '0;
      pad_pu_out    <= '0;
      core_din_out  <= '0;
      osc_en_out    <= '0;
      analog_en_out <= '0;
      cpu_state_out <= ST_POR;
    end else begin
      pad_oe_out    <= oe_nxt;
      pad_out_out   <= out_nxt;
      pad_pu_out    <= pu_nxt;
      core_din_out  <= din_nxt;
      osc_en_out    <= osc_nxt;
      analog_en_out <= ana_nxt;
      cpu_state_out <= cpu_state_r;
    end
  end

  sequence ds_then_run;
    cpu_state_r == ST_DS_HOLD ##1 (no_rst_c && io_hold_control_in &&
                                    pwr_mode_in == PM_RUN);
  endsequence

  chk_por_state: assert property (por_sync_r |=> cpu_state_r == ST_POR)
                   else $error("power-on state missed");
  chk_ext_state: assert property (!por_sync_r && !ext_sync_n_r |=>
                   cpu_state_r == ST_EXT_RST) else $error("external reset state missed");
  chk_standby_map: assert property (no_rst_c && pwr_mode_in == PM_STOP |=>
                     cpu_state_r == ($past(standby_pin_level_bit_in) ? ST_SB_SHUT :
                     ST_SB_HOLD)) else $error("standby state");
  chk_deep_map: assert property (no_rst_c && pwr_mode_in == PM_DS_STOP |=>
                  cpu_state_r == ($past(standby_pin_level_bit_in) ? ST_DS_SHUT :
                  ST_DS_HOLD)) else $error("deep standby state");
  chk_ds_return: assert property (ds_then_run |=> cpu_state_r == ST_DS_RET)
                   else $error("deep standby return not held");
endmodule // pad_state_controller

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
  import pad_state_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_n_in, por_in, ext_reset_n_in, pin_level, io_hold;
  pwr_mode_t  pwr_mode;
  pin_type_t  pin_type [8];
  func_sel_t  func_sel [8];
  logic [7:0] g_out, g_oe, g_pu, p_out, p_oe, p_pu, cfg, osc_run, pad_pin;
  logic [7:0] pad_out_out, pad_oe_out, pad_pu_out, core_din_out, osc_en_out, analog_en_out;
  cpu_state_t cpu_state_out;
  int         bad_count = 0;
  int         comparisons = 0;

  always #50 clk_in = ~clk_in;

  pad_state_controller #(.N_PINS(8)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_in(por_in),
    .ext_reset_n_in(ext_reset_n_in), .pwr_mode_in(pwr_mode), .standby_pin_level_bit_in(pin_level),
    .io_hold_control_in(io_hold), .pin_type_in(pin_type), .func_sel_in(func_sel),
    .gpio_out_in(g_out), .gpio_oe_in(g_oe), .gpio_pu_in(g_pu), .periph_out_in(p_out),
    .periph_oe_in(p_oe), .periph_pu_in(p_pu), .pullup_config_register_in(cfg),
    .osc_running_in(osc_run), .pad_pin_in(pad_pin), .pad_out_out(pad_out_out),
    .pad_oe_out(pad_oe_out), .pad_pu_out(pad_pu_out), .core_din_out(core_din_out),
    .osc_en_out(osc_en_out), .analog_en_out(analog_en_out), .cpu_state_out(cpu_state_out));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle;
    repeat (6) @(negedge clk_in);
  endtask

  // Bounded wait on the reported state; a timeout ends the run as a failure.
  task automatic go(input cpu_state_t s);
    int i;
    i = 0;
    while (cpu_state_out !== s && i < 40) begin
      @(negedge clk_in);
      i++;
    end
    check("cpu_state", {5'h0, cpu_state_out}, {5'h0, s});
    if (cpu_state_out !== s) report_and_stop();
    settle();
  endtask

  task automatic mode(input pwr_mode_t m, input logic l, input logic h);
    @(posedge clk_in);
    pwr_mode  <= m;
    pin_level <= l;
    io_hold   <= h;
  endtask

  task automatic gpio(input logic [7:0] o, input logic [7:0] e, input logic [7:0] u);
    @(posedge clk_in);
    g_out <= o;
    g_oe  <= e;
    g_pu  <= u;
  endtask

  task automatic test_run;
    check("oe", pad_oe_out, 8'hc3);
    check("out", pad_out_out, 8'hc1);
    check("pu", pad_pu_out, 8'he1);
    check("din", core_din_out, 8'hf3);
    check("osc_en", osc_en_out, 8'h08);
    check("analog_en", analog_en_out, 8'h04);
    @(posedge clk_in);
    osc_run <= 8'h00;
    cfg     <= 8'h00;
    settle();
    check("din_clk", core_din_out & 8'h10, 8'h00);
    check("pu_cfg", pad_pu_out & 8'h20, 8'h00);
    @(posedge clk_in);
    func_sel[2] <= FN_GPIO;
    settle();
    check("analog_off", analog_en_out, 8'h00);
    check("oe_digital", pad_oe_out & 8'h04, 8'h04);
    $display("test run done");
  endtask

  task automatic test_resets;
    @(posedge clk_in);
    ext_reset_n_in <= 1'b0;
    go(ST_EXT_RST);
    check("pu_ext", pad_pu_out & 8'h42, 8'h40);
    check("oe_ext", pad_oe_out & 8'h02, 8'h00);
    check("din_ext", core_din_out & 8'h02, 8'h02);
    @(posedge clk_in);
    ext_reset_n_in <= 1'b1;
    por_in         <= 1'b1;
    go(ST_POR);
    check("oe_por", pad_oe_out, 8'h00);
    check("pu_por", pad_pu_out, 8'h00);
    check("din_por", core_din_out, 8'h00);
    check("osc_por", osc_en_out, 8'h00);
    @(posedge clk_in);
    por_in <= 1'b0;
    go(ST_RUN);
    $display("test resets done");
  endtask

  task automatic test_standby;
    pwr_mode_t  m [4] = '{PM_SLEEP, PM_TIMER, PM_RTC, PM_STOP};
    cpu_state_t s [4] = '{ST_RUN, ST_SB_HOLD, ST_SB_HOLD, ST_SB_HOLD};
    gpio(8'ha5, 8'hff, 8'hff);
    foreach (m[k]) begin
      mode(m[k], 1'b0, 1'b0);
      go(s[k]);
    end
    gpio(8'h00, 8'h00, 8'h00);
    settle();
    check("oe_hold", pad_oe_out & 8'h03, 8'h03);
    check("out_hold", pad_out_out & 8'h01, 8'h01);
    check("pu_hold", pad_pu_out & 8'h03, 8'h01);
    check("din_hold", core_din_out & 8'h01, 8'h01);
    mode(PM_STOP, 1'b1, 1'b0);
    go(ST_SB_SHUT);
    check("oe_shut", pad_oe_out & 8'h03, 8'h00);
    check("din_shut", core_din_out & 8'h03, 8'h00);
    $display("test standby done");
  endtask

  task automatic test_deep;
    mode(PM_RUN, 1'b0, 1'b0);
    gpio(8'ha5, 8'hff, 8'hff);
    func_sel[5] <= FN_EXTINT;
    go(ST_RUN);
    mode(PM_DS_STOP, 1'b0, 1'b0);
    go(ST_DS_HOLD);
    gpio(8'h00, 8'h00, 8'h00);
    settle();
    check("oe_ds", pad_oe_out & 8'ha1, 8'ha1);
    check("out_ds", pad_out_out & 8'ha1, 8'ha1);
    check("din_ds", core_din_out & 8'ha1, 8'h00);
    mode(PM_RUN, 1'b0, 1'b1);
    go(ST_DS_RET);
    check("oe_ret", pad_oe_out & 8'h01, 8'h01);
    check("din_ret", core_din_out & 8'h01, 8'h00);
    mode(PM_RUN, 1'b0, 1'b0);
    go(ST_RUN);
    check("oe_run", pad_oe_out & 8'h01, 8'h00);
    gpio(8'hff, 8'hff, 8'hff);
    mode(PM_DS_RTC, 1'b1, 1'b0);
    go(ST_DS_SHUT);
    check("oe_dshut", pad_oe_out & 8'h03, 8'h00);
    check("din_dshut", core_din_out & 8'h03, 8'h00);
    $display("test deep done");
  endtask

  initial begin
    rst_n_in = 1'b0;
    por_in = 1'b0;
    ext_reset_n_in = 1'b1;
    pin_level = 1'b0;
    io_hold = 1'b0;
    pwr_mode = PM_RUN;
    pin_type = '{TYPE_A, TYPE_G, TYPE_I, TYPE_B, TYPE_A, TYPE_J, TYPE_H, TYPE_B};
    func_sel = '{FN_GPIO, FN_GPIO, FN_ANALOG, FN_OSC, FN_EXTCLK, FN_WAKEUP, FN_DEBUG, FN_GPIO};
    {g_out, g_oe, g_pu} = {8'ha5, 8'hff, 8'hff};
    {p_out, p_oe, p_pu} = {8'h40, 8'h40, 8'h40};
    cfg = 8'h20;
    osc_run = 8'h10;
    pad_pin = 8'hff;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    go(ST_RUN);
    test_run();
    test_resets();
    test_standby();
    test_deep();
    report_and_stop();
  end
endmodule // tb
